// >>> hdl/sep_cmd_protect.v
// command decode, pause and write protection front end of a serial eeprom
//
// Contract
// - after reset, deselected and standby; latch and busy cleared; protect bits reloaded from nvStatusInit.
// - stay unselected until chip select is seen high then low.
// - select low is active; high deselects; standby only when not busy.
// - pause starts only while selected, pause low with serial clock low.
// - paused: output released, data and clock ignored, bit position kept.
// - deselect during pause resets protocol, keeps latch and busy flags.
// - complete write command still launches its write cycle on such deselect.
// - writes execute only if clock pulses while selected and not paused are a multiple of eight.
// - latch set only by set command; modifying commands refused while clear.
// - non-read commands need deselect right after last bit's rising edge; a status write still executes if extra whole bytes follow its data byte.
// - block protect bits select none, quarter, half or whole array protected.
// - status lock bit and protect pin decide if protect bits may change.
// - commands are whole bytes, msb first, opcode first then address/data.
// - unknown opcode: ignore everything, output released, until deselect.
// - decode set, clear, status read/write, array read/write opcodes.
// - decode id page read/lock-status read and id page write/lock opcodes.
// - array commands take two address bytes; top bit ignored.
// - id page uses six low address bits; lock operations need address exactly 0x0400.
// - after set-latch opcode ignore input, set latch at deselect.
// - latch cleared at reset, clear command, end of status or array write.
// - lock bit high and protect pin low: status bits read-only, status writes refused.
// - input sampled on rising serial clock, output changes on falling edge.
// - busy reads one during a status, array or id page write cycle, else zero.
`include "sep_defines.vh"
module sep_cmd_protect #(
  parameter [`SEP_CNT_W-1:0] WRITE_CYC = `SEP_TW_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire spiClk,
  input wire csN,
  input wire mosi,
  input wire holdN,
  input wire wpN,
  output reg miso,
  output reg misoOe,
  input wire [2:0] nvStatusInit,
  output reg [2:0] statusNv,
  output reg writeLatch,
  output reg writeBusy,
  output reg standby,
  input wire idLocked,
  output reg rdReq,
  output reg rdSpace,
  output reg [14:0] rdAddr,
  input wire [7:0] rdData,
  output reg wrValid,
  output reg [1:0] wrKind,
  output reg wrSpace,
  output reg [14:0] wrAddr,
  output reg [7:0] wrData,
  input wire wrReady
);
  localparam [5:0] S_OP = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_WDAT = 6'h04;
  localparam [5:0] S_SDAT = 6'h08;
  localparam [5:0] S_RD = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  function isProt;
    input [1:0] bp;
    input [14:0] a;
    begin
      case (bp)
        2'b01: isProt = (a >= `SEP_PROT_QUARTER);
        2'b10: isProt = (a >= `SEP_PROT_HALF);
        2'b11: isProt = 1'b1;
        default: isProt = 1'b0;
      endcase
    end
  endfunction

  reg rstS1_q, rstS2_q;
  reg sclk1_q, sclk2_q, sclk3_q;
  reg cs1_q, cs2_q, cs3_q;
  reg din1_q, din2_q, hold1_q, hold2_q, wp1_q, wp2_q;
  reg nvLoaded_q, armed_q, pause_q;
  reg [5:0] state_q;
  reg [7:0] op_q, sh_q, outSh_q, newStat_q;
  reg [2:0] bitCnt_q, byteCnt_q;
  reg [15:0] addr_q;
  reg space_q, lsRead_q, writeOk_q, pushedAny_q, lost_q;
  reg endPend_q, endOk_q, statPend_q;
  reg pushV_q;
  reg [`SEP_E_W-1:0] pushE_q, spare_q;
  reg spareV_q;
  reg [`SEP_CNT_W-1:0] wipCnt_q;
  wire rstInt_n = rstS2_q;
  wire sel = armed_q & ~cs2_q;
  wire active = sel & ~pause_q;
  wire sclkRise = sclk2_q & ~sclk3_q & active;
  wire sclkFall = ~sclk2_q & sclk3_q & active;
  wire csRise = cs2_q & ~cs3_q & armed_q;
  wire hardware_protect_mode = statusNv[`SEP_NV_LOCK] & ~wp2_q;
  wire [7:0] inByte = {sh_q[6:0], din2_q};
  wire byteDone = sclkRise & (bitCnt_q == 3'h7);
  wire [15:0] nextAddr = {addr_q[7:0], inByte};
  wire [7:0] statByte = {statusNv[2], 3'h0, statusNv[1:0], writeLatch, writeBusy};
  wire [7:0] rdSrc = (op_q == `SEP_OP_STAT_RD) ? statByte :
    (lsRead_q ? {7'h00, idLocked} : rdData);
  wire pop = wrValid & wrReady;
  wire bufReady = ~spareV_q | pop;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstS1_q <= 1'b0;
      rstS2_q <= 1'b0;
    end
    else
    begin
      rstS1_q <= 1'b1;
      rstS2_q <= rstS1_q;
    end
  end

  // pin synchronisers
  always @(posedge clk_sys or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      sclk1_q <= 1'b0; sclk2_q <= 1'b0; sclk3_q <= 1'b0;
      cs1_q <= 1'b0; cs2_q <= 1'b0; cs3_q <= 1'b0;
      din1_q <= 1'b0; din2_q <= 1'b0;
      hold1_q <= 1'b1; hold2_q <= 1'b1;
      wp1_q <= 1'b1; wp2_q <= 1'b1;
    end
    else
    begin
      sclk1_q <= spiClk; sclk2_q <= sclk1_q; sclk3_q <= sclk2_q;
      cs1_q <= csN; cs2_q <= cs1_q; cs3_q <= cs2_q;
      din1_q <= mosi; din2_q <= din1_q;
      hold1_q <= holdN; hold2_q <= hold1_q;
      wp1_q <= wpN; wp2_q <= wp1_q;
    end
  end

  always @(posedge clk_sys or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      nvLoaded_q <= 1'b0;
      statusNv <= 3'h0;
      armed_q <= 1'b0;
      pause_q <= 1'b0;
      state_q <= S_OP;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      outSh_q <= 8'h00;
      newStat_q <= 8'h00;
      bitCnt_q <= 3'h0;
      byteCnt_q <= 3'h0;
      addr_q <= 16'h0000;
      space_q <= 1'b0;
      lsRead_q <= 1'b0;
      writeOk_q <= 1'b0;
      pushedAny_q <= 1'b0;
      lost_q <= 1'b0;
      endPend_q <= 1'b0;
      endOk_q <= 1'b0;
      statPend_q <= 1'b0;
      pushV_q <= 1'b0;
      pushE_q <= {`SEP_E_W{1'b0}};
      wipCnt_q <= {`SEP_CNT_W{1'b0}};
      writeLatch <= 1'b0;
      writeBusy <= 1'b0;
      standby <= 1'b1;
      miso <= 1'b0;
      misoOe <= 1'b0;
      rdReq <= 1'b0;
      rdSpace <= 1'b0;
      rdAddr <= 15'h0000;
    end
    else
    begin
      nvLoaded_q <= 1'b1;
      if (!nvLoaded_q)
        statusNv <= nvStatusInit;
      if (cs2_q)
        armed_q <= 1'b1;
      if (!sel || hold2_q)
        pause_q <= 1'b0;
      else if (!sclk2_q)
        pause_q <= 1'b1;
      standby <= ~sel & ~writeBusy;
      misoOe <= active & (state_q == S_RD);
      rdReq <= 1'b0;
      pushV_q <= 1'b0;
      if (pushV_q && !bufReady)
        lost_q <= 1'b1;
      if (writeBusy)
      begin
        if (wipCnt_q == {`SEP_CNT_W{1'b0}})
        begin
          writeBusy <= 1'b0;
          writeLatch <= 1'b0;
          if (statPend_q)
            statusNv <= {newStat_q[`SEP_ST_LOCK], newStat_q[`SEP_ST_BPHI],
              newStat_q[`SEP_ST_BPLO]};
          statPend_q <= 1'b0;
        end
        else
          wipCnt_q <= wipCnt_q - 1'b1;
      end
      if (endPend_q && !pushV_q && bufReady)
      begin
        endPend_q <= 1'b0;
        pushV_q <= 1'b1;
        pushE_q <= {(endOk_q && !lost_q) ? `SEP_K_COMMIT : `SEP_K_ABORT, 24'h000000};
        if (endOk_q && !lost_q)
        begin
          writeBusy <= 1'b1;
          wipCnt_q <= WRITE_CYC - 1'b1;
        end
      end
      if (csRise)
      begin
        // protocol reset, flags kept when paused
        state_q <= S_OP;
        bitCnt_q <= 3'h0;
        byteCnt_q <= 3'h0;
        pause_q <= 1'b0;
        if (!pause_q && state_q == S_WAIT && bitCnt_q == 3'h0 && byteCnt_q == 3'h1)
        begin
          if (op_q == `SEP_OP_SET_LATCH)
            writeLatch <= 1'b1;
          else if (op_q == `SEP_OP_CLR_LATCH)
            writeLatch <= 1'b0;
        end
        if (state_q == S_SDAT && bitCnt_q == 3'h0 && byteCnt_q >= 3'h2 &&
          writeLatch && !hardware_protect_mode && !writeBusy)
        begin
          statPend_q <= 1'b1;
          writeBusy <= 1'b1;
          wipCnt_q <= WRITE_CYC - 1'b1;
        end
        if (state_q == S_WDAT && pushedAny_q)
        begin
          endPend_q <= 1'b1;
          endOk_q <= (bitCnt_q == 3'h0);
        end
      end
      else if (sclkRise)
      begin
        sh_q <= inByte;
        bitCnt_q <= bitCnt_q + 1'b1;
        if (byteDone && byteCnt_q != 3'h7)
          byteCnt_q <= byteCnt_q + 1'b1;
        if (byteDone)
        begin
          case (state_q)
            S_OP:
            begin
              op_q <= inByte;
              lost_q <= 1'b0;
              pushedAny_q <= 1'b0;
              lsRead_q <= 1'b0;
              case (inByte)
                `SEP_OP_STAT_RD: state_q <= S_RD;
                `SEP_OP_STAT_WR: state_q <= S_SDAT;
                `SEP_OP_ARR_RD, `SEP_OP_ARR_WR, `SEP_OP_ID_RD, `SEP_OP_ID_WR:
                  state_q <= S_ADDR;
                default: state_q <= S_WAIT;
              endcase
            end
            S_ADDR:
            begin
              addr_q <= nextAddr;
              if (byteCnt_q == 3'h2)
              begin
                space_q <= op_q[7];
                if (!op_q[7])
                  state_q <= op_q[0] ? S_RD : S_WDAT;
                else if ((nextAddr & `SEP_ID_HI_MASK) == 16'h0000)
                  state_q <= op_q[0] ? S_RD : S_WDAT;
                else if (nextAddr == `SEP_ID_LOCK_ADDR)
                begin
                  state_q <= op_q[0] ? S_RD : S_WDAT;
                  lsRead_q <= op_q[0];
                end
                else
                  state_q <= S_WAIT;
                writeOk_q <= writeLatch & ~writeBusy & (op_q[7] ? ~idLocked :
                  ~isProt(statusNv[1:0], nextAddr[14:0]));
                rdReq <= op_q[0];
                rdSpace <= op_q[7];
                rdAddr <= nextAddr[14:0];
              end
            end
            S_WDAT:
              if (writeOk_q)
              begin
                pushV_q <= 1'b1;
                pushE_q <= {`SEP_K_DATA, space_q, addr_q[14:0], inByte};
                pushedAny_q <= 1'b1;
                addr_q <= {addr_q[15:6], addr_q[5:0] + 6'h01};
              end
            S_SDAT:
              if (byteCnt_q == 3'h1)
                newStat_q <= inByte;
            S_RD:
              if (op_q != `SEP_OP_STAT_RD && !lsRead_q)
              begin
                addr_q <= addr_q + 16'h0001;
                rdReq <= 1'b1;
                rdAddr <= addr_q[14:0] + 15'h0001;
              end
            S_WAIT:
              state_q <= S_WAIT;
            default:
              state_q <= S_OP;
          endcase
        end
      end
      if (sclkFall && state_q == S_RD)
      begin
        if (bitCnt_q == 3'h0)
        begin
          miso <= rdSrc[7];
          outSh_q <= {rdSrc[6:0], 1'b0};
        end
        else
        begin
          miso <= outSh_q[7];
          outSh_q <= {outSh_q[6:0], 1'b0};
        end
      end
    end
  end

  // two-entry output buffer
  always @(posedge clk_sys or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      wrValid <= 1'b0;
      {wrKind, wrSpace, wrAddr, wrData} <= {`SEP_E_W{1'b0}};
      spare_q <= {`SEP_E_W{1'b0}};
      spareV_q <= 1'b0;
    end
    else if (pop)
    begin
      if (spareV_q)
      begin
        {wrKind, wrSpace, wrAddr, wrData} <= spare_q;
        if (pushV_q)
          spare_q <= pushE_q;
        else
          spareV_q <= 1'b0;
      end
      else if (pushV_q)
        {wrKind, wrSpace, wrAddr, wrData} <= pushE_q;
      else
        wrValid <= 1'b0;
    end
    else if (pushV_q && bufReady)
    begin
      if (!wrValid)
      begin
        {wrKind, wrSpace, wrAddr, wrData} <= pushE_q;
        wrValid <= 1'b1;
      end
      else
      begin
        spare_q <= pushE_q;
        spareV_q <= 1'b1;
      end
    end
  end
endmodule

// >>> include/sep_defines.vh
// constants for the serial eeprom command and protection front end
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH
// opcodes
`define SEP_OP_SET_LATCH 8'h06
`define SEP_OP_CLR_LATCH 8'h04
`define SEP_OP_STAT_RD 8'h05
`define SEP_OP_STAT_WR 8'h01
`define SEP_OP_ARR_RD 8'h03
`define SEP_OP_ARR_WR 8'h02
`define SEP_OP_ID_RD 8'h83
`define SEP_OP_ID_WR 8'h82
// status byte bit positions
`define SEP_ST_BUSY 0
`define SEP_ST_LATCH 1
`define SEP_ST_BPLO 2
`define SEP_ST_BPHI 3
`define SEP_ST_LOCK 7
// nonvolatile field layout {status_write_lock, block_protect_hi, block_protect_lo}
`define SEP_NV_LOCK 2
// protected range bounds
`define SEP_PROT_QUARTER 15'h6000
`define SEP_PROT_HALF 15'h4000
// identification page addressing
`define SEP_ID_LOCK_ADDR 16'h0400
`define SEP_ID_HI_MASK 16'hffc0
// buffer entry kinds
`define SEP_K_DATA 2'h0
`define SEP_K_COMMIT 2'h1
`define SEP_K_ABORT 2'h2
// entry layout {kind[1:0], space, addr[14:0], data[7:0]}
`define SEP_E_W 26
// write cycle time
`define SEP_CLK_NS 8
`define SEP_TW_MS 5
// 5 ms at 8 ns clock
`define SEP_TW_CYC 20'h98968
`define SEP_CNT_W 20
`endif

// >>> testbench/sep_cmd_protect_chk_asserts.sv
// port assertions for the command and protection front end
module sep_cmd_protect_chk #(
  parameter [19:0] WRITE_CYC = 20'h00032
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic holdN,
  input wire logic misoOe,
  input wire logic writeLatch,
  input wire logic writeBusy,
  input wire logic standby,
  input wire logic wrValid,
  input wire logic [1:0] wrKind,
  input wire logic [7:0] wrData,
  input wire logic wrReady
);
  logic [19:0] busyCnt_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // cycles spent busy
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      busyCnt_q <= 20'h0;
    else
      busyCnt_q <= writeBusy ? busyCnt_q + 20'h1 : 20'h0;
  property p_rstClear;
    $rose(rst_n) |-> !writeLatch && !writeBusy && standby;
  endproperty
  a_rstClear: assert property (p_rstClear) else $error("reset state");
  property p_deselOe;
    csN [*6] |-> !misoOe;
  endproperty
  a_deselOe: assert property (p_deselOe) else $error("driving deselected");
  property p_pauseOe;
    (!holdN && !spiClk) [*6] |-> !misoOe;
  endproperty
  a_pauseOe: assert property (p_pauseOe) else $error("driving paused");
  property p_busyLen;
    $fell(writeBusy) |-> busyCnt_q == WRITE_CYC;
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("busy length");
  property p_latchEnd;
    $fell(writeBusy) |-> ##[0:2] !writeLatch;
  endproperty
  a_latchEnd: assert property (p_latchEnd) else $error("latch kept");
  property p_busyLatch;
    $rose(writeBusy) |-> $past(writeLatch);
  endproperty
  a_busyLatch: assert property (p_busyLatch) else $error("write no latch");
  property p_bufHold;
    wrValid && !wrReady |=> wrValid && $stable(wrKind) && $stable(wrData);
  endproperty
  a_bufHold: assert property (p_bufHold) else $error("entry moved");
  property p_latchSet;
    $rose(writeLatch) |-> csN;
  endproperty
  a_latchSet: assert property (p_latchSet) else $error("latch while selected");
  c_write: cover property ($rose(writeBusy));
  c_stall: cover property (wrValid && !wrReady);
  c_drive: cover property (misoOe);
endmodule
bind sep_cmd_protect sep_cmd_protect_chk #(.WRITE_CYC(WRITE_CYC)) chk (.clk_sys, .rst_n,
  .spiClk, .csN, .holdN, .misoOe, .writeLatch, .writeBusy, .standby, .wrValid, .wrKind,
  .wrData, .wrReady);

// >>> testbench/sep_spi_master.sv
// serial bus master model
module sep_spi_master (
  output logic spiClk = 1'b0,
  output logic csN = 1'b1,
  output logic mosi = 1'b0,
  output logic holdN = 1'b1,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  task sel();
    csN = 1'b0;
    #100;
  endtask
  task desel();
    #30;
    csN = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
  task bits(input logic [7:0] b, input int n, output logic [7:0] q);
    for (int i = 0; i < n && i < 8; i++)
    begin
      mosi = b[7-i];
      #62.5;
      spiClk = 1'b1;
      q = {q[6:0], miso};
      #62.5;
      spiClk = 1'b0;
    end
  endtask
  task pause();
    holdN = 1'b0;
    repeat (4) #60 spiClk = ~spiClk;
    csN = 1'b1;
    #300;
    holdN = 1'b1;
    #200;
  endtask
endmodule

// >>> testbench/test_sep_cmd_protect.sv
// self-checking bench for the command front end
module test_sep_cmd_protect;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] SET_CMD = 48'h060000000000;
  logic clk_sys = 1'b0, rst_n = 1'b0, wpN = 1'b1, idLocked = 1'b0, wrReady = 1'b1;
  logic [2:0] nvStatusInit = 3'h0;
  logic [7:0] rdData = 8'h00, r;
  logic [14:0] lastAddr;
  logic [7:0] lastData;
  wire spiClk, csN, mosi, holdN, miso, misoOe, writeLatch, writeBusy, standby, rdReq;
  wire rdSpace, wrValid, wrSpace;
  wire [1:0] wrKind;
  wire [14:0] rdAddr, wrAddr;
  wire [7:0] wrData;
  wire [2:0] statusNv;
  // released line shows inverse
  wire misoLine = misoOe ? miso : ~miso;
  int err_total, n_checks, nBusy, nAbort;
  logic [23:0] rows [9] = '{24'h107fff, 24'h115fff, 24'h016000, 24'h123fff,
    24'h024000, 24'h030000, 24'h01ffff, 24'h11dfff, 24'h140123};
  sep_cmd_protect #(.WRITE_CYC(20'h00032)) uut (.clk_sys, .rst_n, .spiClk, .csN,
    .mosi, .holdN, .wpN, .miso, .misoOe, .nvStatusInit, .statusNv, .writeLatch,
    .writeBusy, .standby, .idLocked, .rdReq, .rdSpace, .rdAddr, .rdData, .wrValid,
    .wrKind, .wrSpace, .wrAddr, .wrData, .wrReady);
  sep_spi_master m (.spiClk, .csN, .mosi, .holdN, .miso(misoLine));
  initial
    forever #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    rdData <= rdAddr[7:0] ^ 8'ha5;
  always @(posedge clk_sys)
  begin
    nBusy += $rose(writeBusy);
    nAbort += (wrValid && wrReady && wrKind == 2'h2);
    if (wrValid && wrReady && wrKind == 2'h0)
    begin
      lastAddr <= wrAddr;
      lastData <= wrData;
    end
  end
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask
  task test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task rst(input logic [2:0] nv);
    rst_n = 1'b0;
    nvStatusInit = nv;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
  endtask
  task tx(input logic [47:0] w, input int n, input bit p);
    m.sel();
    for (int i = 0; i < n; i += 8)
      m.bits(w[47-i -: 8], n - i, r);
    if (p)
      m.pause();
    else
      m.desel();
    for (int k = 0; k < 200 && writeBusy !== 1'b0; k++)
      @(negedge clk_sys);
    if (writeBusy !== 1'b0)
    begin
      $display("[ERR] writeBusy exp 0 got 1");
      err_total++;
      test_done();
    end
    repeat (4) @(negedge clk_sys);
  endtask
  initial
  begin
    @(negedge clk_sys);
    m.csN = 1'b0;
    rst(3'h0);
    chk("rstState", 16'h0001, {writeLatch, writeBusy, standby});
    m.bits(8'h06, 8, r);
    m.desel();
    chk("noFall", 16'h0000, writeLatch);
    foreach (rows[j])
    begin
      rst(rows[j][18:16]);
      chk("statusNv", rows[j][18:16], statusNv);
      tx(SET_CMD, 8, 0);
      chk("latchSet", 16'h0001, writeLatch);
      nBusy = 0;
      tx({8'h02, rows[j][15:0], 24'h3c0000}, 32, 0);
      chk("protect", rows[j][20], 16'(nBusy));
    end
    chk("addr", 16'h0123, lastAddr);
    chk("data", 16'h003c, lastData);
    nBusy = 0;
    tx(48'h020011220000, 32, 0);
    chk("noLatch", 16'h0000, 16'(nBusy));
    tx(SET_CMD, 8, 0);
    tx(48'h040000000000, 8, 0);
    chk("clrLatch", 16'h0000, writeLatch);
    tx(SET_CMD, 8, 0);
    tx(48'h0200105500ff, 35, 0);
    chk("align", 16'h0000, 16'(nBusy));
    tx(SET_CMD, 8, 0);
    tx(48'h050000000000, 16, 1);
    chk("status", 16'h0082, r);
    chk("keepLatch", 16'h0001, writeLatch);
    tx(48'h020050770000, 32, 1);
    chk("pauseWr", 16'h0001, 16'(nBusy));
    tx(48'h038123000000, 32, 0);
    chk("rdByte", 16'h0086, r);
    idLocked = 1'b1;
    tx(48'h830400000000, 32, 0);
    chk("lockRd", 16'h0001, r);
    tx(SET_CMD, 8, 0);
    nAbort = 0;
    wrReady = 1'b0;
    tx(48'h020040112233, 48, 0);
    wrReady = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("overflow", 16'h0001, 16'(nAbort));
    rst(3'h4);
    wpN = 1'b0;
    tx(SET_CMD, 8, 0);
    tx(48'h010c00000000, 16, 0);
    chk("hwProt", 16'h0004, statusNv);
    wpN = 1'b1;
    tx(SET_CMD, 8, 0);
    tx(48'h010c00000000, 16, 0);
    chk("swProt", 16'h0003, statusNv);
    tx(48'haa0600000000, 16, 0);
    chk("badOp", 16'h0000, writeLatch);
    test_done();
  end
endmodule
